// ===== src/ubst_top.v
// ubst_top.v : four unbalance stages with event output, fault store and register port
`timescale 1ns/1ps
`default_nettype none
`include "ubst_map.vh"
module ubst_top #(
  parameter integer TICK_CYCLES = `UBST_TICK_MS * `UBST_CLK_KHZ
) (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire [15:0] neg_seq_i,
  input  wire [15:0] pos_seq_i,
  input  wire [15:0] zero_seq_i,
  input  wire [15:0] neg_ang_i,
  input  wire [15:0] pos_ang_i,
  input  wire [15:0] zero_ang_i,
  input  wire [3:0]  block_i,
  input  wire [2:0]  setting_group_i,
  output reg  [3:0]  start_o,
  output reg  [3:0]  trip_o,
  output reg  [3:0]  blocked_o,
  output reg  [23:0] event_o,
  output reg  [31:0] event_time_o,
  output reg         irq_o
);
  // ---------------------------------------------------------------------------
  // 1 ms tick and time stamp
  // ---------------------------------------------------------------------------
  reg  [31:0] tcnt_q;
  reg         tick_q;
  reg  [31:0] ms_q;

  // tick pulse every millisecond drives all timers and the time stamp
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      tcnt_q <= 32'h00000000;
      tick_q <= 1'b0;
      ms_q   <= 32'h00000000;
    end else begin
      tick_q <= (tcnt_q == TICK_CYCLES - 1); // see [RQ17]
      tcnt_q <= (tcnt_q == TICK_CYCLES - 1) ? 32'h00000000 : tcnt_q + 32'h00000001;
      if (tick_q) ms_q <= ms_q + 32'h00000001; // see [RQ16]
    end
  end

  // ---------------------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------------------
  reg  [6:0]  mode_q [0:3];
  reg  [15:0] pick_q [0:3];
  reg  [15:0] dly_q  [0:3];
  reg  [15:0] rel_q  [0:3];
  reg  [15:0] kmul_q [0:3];
  reg  [24:0] user_q [0:3];
  reg  [23:0] evmask_q;
  reg  [3:0]  ien_q;
  reg  [3:0]  rsel_q;
  wire [1:0]  ws = addr_i[6:5];
  integer     k;

  // register writes; unmapped addresses are ignored
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (k = 0; k < `UBST_STAGES; k = k + 1) begin
        mode_q[k] <= `UBST_MODE_DEF;
        pick_q[k] <= `UBST_PICK_DEF;
        dly_q[k]  <= `UBST_DLY_DEF;
        rel_q[k]  <= `UBST_REL_DEF; // see [RQ6]
        kmul_q[k] <= `UBST_K_DEF;
        user_q[k] <= {9'h000, `UBST_UA_DEF};
      end
      evmask_q <= 24'hFFFFFF;
      ien_q    <= 4'h0;
      rsel_q   <= 4'h0;
    end else if (wr_i) begin
      if (addr_i[`UBST_STG_BIT]) begin
        case (addr_i[4:0])
          `UBST_S_MODE: mode_q[ws] <= wdata_i[6:0];
          `UBST_S_PICK: pick_q[ws] <= wdata_i[15:0];
          `UBST_S_DLY:  dly_q[ws]  <= wdata_i[15:0];
          `UBST_S_REL:  rel_q[ws]  <= wdata_i[15:0];
          `UBST_S_KMUL: kmul_q[ws] <= wdata_i[15:0];
          `UBST_S_USER: user_q[ws] <= wdata_i[24:0];
          default: ;
        endcase
      end else begin
        case (addr_i)
          `UBST_A_EVMASK: evmask_q <= wdata_i[23:0]; // see [RQ9]
          `UBST_A_IEN:    ien_q    <= wdata_i[3:0];
          `UBST_A_RSEL:   rsel_q   <= wdata_i[3:0]; // see [RQ18]
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // stages
  // ---------------------------------------------------------------------------
  wire [3:0]  st_s;
  wire [3:0]  st_t;
  wire [3:0]  st_b;
  wire [3:0]  st_p;
  wire [63:0] st_rem;

  genvar g;
  generate
    for (g = 0; g < `UBST_STAGES; g = g + 1) begin : g_stg // see [RQ10]
      ubst_stage u_stage (
        .clk_i     (ref_clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick_q),
        .meas_i    (neg_seq_i),
        .block_i   (block_i[g]),
        .mode_i    (mode_q[g]),
        .pickup_i  (pick_q[g]),
        .delay_i   (dly_q[g]),
        .release_i (rel_q[g]),
        .kmul_i    (kmul_q[g]),
        .user_i    (user_q[g]),
        .start_o   (st_s[g]),
        .trip_o    (st_t[g]),
        .blocked_o (st_b[g]),
        .pick_o    (st_p[g]),
        .remain_o  (st_rem[g*16+:16])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // events: six edge kinds per stage, bit = stage * 6 + kind
  // ---------------------------------------------------------------------------
  reg  [23:0] edg;
  reg  [11:0] rise;
  integer     s;

  // kinds: start on/off, trip on/off, blocked on/off
  always @* begin
    edg  = 24'h000000;
    rise = 12'h000;
    for (s = 0; s < `UBST_STAGES; s = s + 1) begin
      edg[s*6+0]  = st_s[s] & ~start_o[s]; // see [RQ8]
      edg[s*6+1]  = ~st_s[s] & start_o[s];
      edg[s*6+2]  = st_t[s] & ~trip_o[s];
      edg[s*6+3]  = ~st_t[s] & trip_o[s];
      edg[s*6+4]  = st_b[s] & ~blocked_o[s];
      edg[s*6+5]  = ~st_b[s] & blocked_o[s];
      rise[s*3+0] = edg[s*6+0]; // see [RQ12]
      rise[s*3+1] = edg[s*6+2];
      rise[s*3+2] = edg[s*6+4];
    end
  end

  // outputs mirror the stages one cycle later with their edge events
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      start_o      <= 4'h0;
      trip_o       <= 4'h0;
      blocked_o    <= 4'h0;
      event_o      <= 24'h000000;
      event_time_o <= 32'h00000000;
    end else begin
      start_o      <= st_s;
      trip_o       <= st_t;
      blocked_o    <= st_b;
      event_o      <= edg & evmask_q; // see [RQ9]
      event_time_o <= ms_q; // see [RQ16]
    end
  end

  // ---------------------------------------------------------------------------
  // averages for the records
  // ---------------------------------------------------------------------------
  wire [15:0] avg20;
  wire [15:0] avg200;

  ubst_avg u_avg (
    .clk_i    (ref_clk_i),
    .rst_i    (rst_i),
    .tick_i   (tick_q),
    .sample_i (neg_seq_i),
    .avg_o    (avg20),
    .old_o    (avg200)
  );

  // ---------------------------------------------------------------------------
  // fault store: twelve records, one write per cycle from a pending set
  // ---------------------------------------------------------------------------
  reg  [31:0] r_time [0:`UBST_REC_N-1];
  reg  [15:0] r_id   [0:`UBST_REC_N-1];
  reg  [15:0] r_pre  [0:`UBST_REC_N-1];
  reg  [15:0] r_flt  [0:`UBST_REC_N-1];
  reg  [15:0] r_pf   [0:`UBST_REC_N-1];
  reg  [31:0] r_pos  [0:`UBST_REC_N-1];
  reg  [31:0] r_neg  [0:`UBST_REC_N-1];
  reg  [31:0] r_zer  [0:`UBST_REC_N-1];
  reg  [15:0] r_rem  [0:`UBST_REC_N-1];
  reg  [11:0] pend_q;
  reg  [3:0]  wp_q;
  reg  [3:0]  rcnt_q;
  reg  [3:0]  istat_q;
  reg  [11:0] pick1;
  reg  [3:0]  jsel;
  reg         jv;
  wire [3:0]  jdiv  = jsel / 4'h3;
  wire [3:0]  jrem  = jsel % 4'h3;
  wire [1:0]  jstg  = jdiv[1:0];
  wire [1:0]  jkind = jrem[1:0];
  wire [3:0]  iclr  = (wr_i && !addr_i[`UBST_STG_BIT] && addr_i == `UBST_A_ICLR) ? wdata_i[3:0] : 4'h0;
  reg  [3:0]  iset;
  integer     j;

  // lowest pending trigger is served first
  always @* begin
    jsel  = 4'h0;
    jv    = 1'b0;
    pick1 = 12'h000;
    iset  = 4'h0;
    for (j = `UBST_REC_N - 1; j >= 0; j = j - 1) begin
      if (pend_q[j]) begin
        jsel = j[3:0];
        jv   = 1'b1;
      end
    end
    if (jv) begin
      pick1[jsel] = 1'b1;
      iset[jstg]  = 1'b1;
    end
  end

  // record write, oldest overwritten when full
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      pend_q <= 12'h000;
      wp_q   <= 4'h0;
      rcnt_q <= 4'h0;
    end else begin
      pend_q <= (pend_q & ~pick1) | rise; // new trigger wins over service, see [RQ11]
      if (jv) begin
        r_time[wp_q] <= ms_q; // see [RQ13]
        r_id[wp_q]   <= {8'h00, setting_group_i, jstg, jkind};
        r_pre[wp_q]  <= avg20;
        r_flt[wp_q]  <= neg_seq_i;
        r_pf[wp_q]   <= avg200;
        r_pos[wp_q]  <= {pos_ang_i, pos_seq_i};
        r_neg[wp_q]  <= {neg_ang_i, neg_seq_i};
        r_zer[wp_q]  <= {zero_ang_i, zero_seq_i};
        r_rem[wp_q]  <= st_rem[jstg*16+:16];
        wp_q         <= (wp_q == `UBST_REC_N - 1) ? 4'h0 : wp_q + 4'h1; // see [RQ18]
        if (rcnt_q != `UBST_REC_N) rcnt_q <= rcnt_q + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt: sticky per-stage record flag, set wins over clear
  // ---------------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      istat_q <= 4'h0;
      irq_o   <= 1'b0;
    end else begin
      istat_q <= (istat_q & ~iclr) | iset;
      irq_o   <= |(((istat_q & ~iclr) | iset) & ien_q);
    end
  end

  // ---------------------------------------------------------------------------
  // register reads, data valid only in the cycle after the strobe
  // ---------------------------------------------------------------------------
  wire [4:0]  ridx_r = {1'b0, wp_q} + 5'd11 - {1'b0, rsel_q};
  wire [3:0]  ridx   = (ridx_r >= `UBST_REC_N) ? ridx_r[3:0] - 4'hC : ridx_r[3:0];
  wire        rok    = rsel_q < rcnt_q;
  wire [7:0]  rwo    = addr_i - `UBST_A_REC;
  reg  [31:0] rmux;

  always @* begin
    rmux = 32'h00000000;
    if (addr_i[`UBST_STG_BIT]) begin
      case (addr_i[4:0])
        `UBST_S_MODE: rmux = {25'h0000000, mode_q[ws]};
        `UBST_S_PICK: rmux = {16'h0000, pick_q[ws]};
        `UBST_S_DLY:  rmux = {16'h0000, dly_q[ws]};
        `UBST_S_REL:  rmux = {16'h0000, rel_q[ws]};
        `UBST_S_KMUL: rmux = {16'h0000, kmul_q[ws]};
        `UBST_S_USER: rmux = {7'h00, user_q[ws]};
        `UBST_S_STAT: rmux = {28'h0000000, st_p[ws], st_b[ws], st_t[ws], st_s[ws]};
        default: ;
      endcase
    end else if (addr_i >= `UBST_A_REC && rwo[7:2] < `UBST_REC_W && rwo[1:0] == 2'h0) begin
      if (rok) begin
        case (rwo[5:2])
          4'h0: rmux = r_time[ridx];
          4'h1: rmux = {16'h0000, r_id[ridx]};
          4'h2: rmux = {16'h0000, r_pre[ridx]};
          4'h3: rmux = {16'h0000, r_flt[ridx]};
          4'h4: rmux = {16'h0000, r_pf[ridx]};
          4'h5: rmux = r_pos[ridx];
          4'h6: rmux = r_neg[ridx];
          4'h7: rmux = r_zer[ridx];
          default: rmux = {16'h0000, r_rem[ridx]};
        endcase
      end
    end else begin
      case (addr_i)
        `UBST_A_EVMASK: rmux = {8'h00, evmask_q};
        `UBST_A_ISTAT:  rmux = {28'h0000000, istat_q};
        `UBST_A_IEN:    rmux = {28'h0000000, ien_q};
        `UBST_A_RCNT:   rmux = {28'h0000000, rcnt_q};
        `UBST_A_RSEL:   rmux = {28'h0000000, rsel_q};
        `UBST_A_TIME:   rmux = ms_q;
        default: ;
      endcase
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) rdata_o <= 32'h00000000;
    else       rdata_o <= rd_i ? rmux : 32'h00000000;
  end
endmodule // ubst_top
`default_nettype wire

// ===== include/ubst_map.vh
// ubst_map.vh : register map, field layout and timing constants of the unbalance stage block
// Operation
// [RQ1] instant mode raises trip in the same cycle as start
// [RQ2] fixed-delay mode trips after the set delay of continuous start
// [RQ3] inverse-delay mode trips sooner the larger the excess current
// [RQ4] inverse-delay mode offers IEC curves, IEEE curves and a user curve
// [RQ5] quadratic curve: time equals k over measured squared minus setting squared
// [RQ6] release delay after early drop, default 60 ms, operate time held
// [RQ7] release option keeps timing during release; trip only after pick-up returns
// [RQ8] events on every edge of start, trip and blocked, six kinds
// [RQ9] each event kind has its own mask bit for the event output
// [RQ10] four stages; every event code names its stage
// [RQ11] rising start, trip or blocked is stored with time and measurements
// [RQ12] fault store keeps the latest twelve records of rising edges only
// [RQ13] record holds time, event, averages, fault values, remaining time, setting group
// [RQ14] pick-up under blocking gives blocked; blocking drops start into release
// [RQ15] pick-up releases below 97 percent of its setting
// [RQ16] time stamps count 1 ms; instant start and trip share one stamp
// [RQ17] timers step on one 1 ms tick and saturate
// [RQ18] full store overwrites oldest; read pointer walks newest to oldest
`ifndef UBST_MAP_VH
`define UBST_MAP_VH
// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define UBST_CLK_KHZ    200000
`define UBST_TICK_MS    1
`define UBST_AVG_MS     20
`define UBST_HIST_N     10
`define UBST_REL_DEF    16'h003C
`define UBST_DLY_DEF    16'h0064
`define UBST_K_DEF      16'h0064
`define UBST_PICK_DEF   16'h0100
`define UBST_UA_DEF     16'h03E8
`define UBST_HYST_PCT   97
`define UBST_PCT        100
`define UBST_QUAD_MS    1000
// -----------------------------------------------------------------------------
// sizes and global registers (byte addresses)
// -----------------------------------------------------------------------------
`define UBST_STAGES     4
`define UBST_EV_N       24
`define UBST_REC_N      12
`define UBST_A_EVMASK   8'h00
`define UBST_A_ISTAT    8'h04
`define UBST_A_ICLR     8'h08
`define UBST_A_IEN      8'h0C
`define UBST_A_RCNT     8'h10
`define UBST_A_RSEL     8'h14
`define UBST_A_TIME     8'h18
`define UBST_A_REC      8'h20
`define UBST_REC_W      9
// -----------------------------------------------------------------------------
// per-stage registers: bit 7 set, stage in bits 6:5, offset in bits 4:0
// -----------------------------------------------------------------------------
`define UBST_STG_BIT    7
`define UBST_S_MODE     5'h00
`define UBST_S_PICK     5'h04
`define UBST_S_DLY      5'h08
`define UBST_S_REL      5'h0C
`define UBST_S_KMUL     5'h10
`define UBST_S_USER     5'h14
`define UBST_S_STAT     5'h18
`define UBST_MODE_DEF   7'h41
// mode field: [1:0] operation, [4:2] curve, [5] release option, [6] enable
`define UBST_OP_INST    2'h0
`define UBST_OP_FIXED   2'h1
`define UBST_OP_INV     2'h2
`define UBST_CV_IECVI   3'h0
`define UBST_CV_IECEI   3'h1
`define UBST_CV_IEEEVI  3'h2
`define UBST_CV_IEEEEI  3'h3
`define UBST_CV_USER    3'h4
`define UBST_CV_QUAD    3'h5
// curve multipliers A in 0.001 s, offsets B in ms, at k = 1.00
`define UBST_A_IECVI    32'h000034BC
`define UBST_A_IECEI    32'h00013880
`define UBST_A_IEEEVI   32'h00004C9A
`define UBST_B_IEEEVI   16'h01EB
`define UBST_A_IEEEEI   32'h00006E28
`define UBST_B_IEEEEI   16'h007A
`endif

// ===== src/ubst_avg.v
// ubst_avg.v : 20 ms average of the measured current and its 200 ms history
`timescale 1ns/1ps
`default_nettype none
`include "ubst_map.vh"
module ubst_avg (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        tick_i,
  input  wire [15:0] sample_i,
  output wire [15:0] avg_o,
  output wire [15:0] old_o
);
  reg  [20:0] sum_q;
  reg  [4:0]  n_q;
  reg  [15:0] avg_q;
  reg  [15:0] hist_q [0:`UBST_HIST_N-1];
  reg  [3:0]  hp_q;
  wire [20:0] tot = sum_q + {5'h00, sample_i};
  wire [31:0] quo = tot / `UBST_AVG_MS;
  integer     i;

  // one sample per ms; each closed window shifts into the history ring
  always @(posedge clk_i) begin
    if (rst_i) begin
      sum_q <= 21'h000000;
      n_q   <= 5'h00;
      avg_q <= 16'h0000;
      hp_q  <= 4'h0;
      for (i = 0; i < `UBST_HIST_N; i = i + 1) hist_q[i] <= 16'h0000;
    end else if (tick_i) begin
      if (n_q == `UBST_AVG_MS - 1) begin
        avg_q        <= quo[15:0];
        hist_q[hp_q] <= quo[15:0];
        hp_q         <= (hp_q == `UBST_HIST_N - 1) ? 4'h0 : hp_q + 4'h1;
        sum_q        <= 21'h000000;
        n_q          <= 5'h00;
      end else begin
        sum_q <= tot;
        n_q   <= n_q + 5'h01;
      end
    end
  end

  assign avg_o = avg_q;
  assign old_o = hist_q[hp_q]; // oldest window, about 200 ms back
endmodule // ubst_avg
`default_nettype wire

// ===== src/ubst_stage.v
// ubst_stage.v : pick-up, blocking and trip/release timing of one unbalance stage
`timescale 1ns/1ps
`default_nettype none
`include "ubst_map.vh"
module ubst_stage (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        tick_i,
  input  wire [15:0] meas_i,
  input  wire        block_i,
  input  wire [6:0]  mode_i,
  input  wire [15:0] pickup_i,
  input  wire [15:0] delay_i,
  input  wire [15:0] release_i,
  input  wire [15:0] kmul_i,
  input  wire [24:0] user_i,
  output reg         start_o,
  output reg         trip_o,
  output reg         blocked_o,
  output reg         pick_o,
  output wire [15:0] remain_o
);
  wire [1:0]  op    = mode_i[1:0];
  wire [2:0]  curve = mode_i[4:2];
  wire        relop = mode_i[5];
  wire        en    = mode_i[6];
  reg  [15:0] t_q;
  reg  [47:0] acc_q;
  reg  [15:0] rc_q;
  reg         ract_q;
  reg  [31:0] a_sel;
  reg  [15:0] b_sel;
  reg         p2;

  // curve table; user curve takes A, B and exponent from its register
  always @* begin
    a_sel = {16'h0000, user_i[15:0]};
    b_sel = {8'h00, user_i[23:16]};
    p2    = user_i[24];
    case (curve)
      `UBST_CV_IECVI:  begin a_sel = `UBST_A_IECVI;  b_sel = 16'h0000;       p2 = 1'b0; end // see [RQ4]
      `UBST_CV_IECEI:  begin a_sel = `UBST_A_IECEI;  b_sel = 16'h0000;       p2 = 1'b1; end
      `UBST_CV_IEEEVI: begin a_sel = `UBST_A_IEEEVI; b_sel = `UBST_B_IEEEVI; p2 = 1'b1; end
      `UBST_CV_IEEEEI: begin a_sel = `UBST_A_IEEEEI; b_sel = `UBST_B_IEEEEI; p2 = 1'b1; end
      `UBST_CV_QUAD:   begin a_sel = 32'h00000000;   b_sel = 16'h0000;       p2 = 1'b1; end // see [RQ5]
      default: ;
    endcase
  end

  // pick-up with release below 97 percent of the setting
  wire [31:0] m100   = meas_i * `UBST_PCT;
  wire [31:0] p97    = pickup_i * `UBST_HYST_PCT;
  wire        pick_n = pick_o ? !(m100 < p97) : (meas_i > pickup_i); // see [RQ15]
  wire        start_n = en & pick_n & ~block_i; // see [RQ14]
  wire        blk_n   = en & pick_n & block_i;

  // inverse time: integrate I^p - Iset^p per ms until k*A*Iset^p is reached, k*1000 for the quadratic curve
  wire [31:0] isp   = p2 ? pickup_i * pickup_i : {16'h0000, pickup_i};
  wire [31:0] imp   = p2 ? meas_i * meas_i : {16'h0000, meas_i};
  wire [31:0] inc   = (imp > isp) ? imp - isp : 32'h00000000; // see [RQ3]
  wire [79:0] thr   = (curve == `UBST_CV_QUAD) ? kmul_i * `UBST_QUAD_MS : kmul_i * a_sel * isp; // see [RQ5]
  wire [79:0] accx  = acc_q * `UBST_PCT;
  wire [31:0] bterm = (kmul_i * b_sel) / `UBST_PCT;
  wire        done_inv = (accx >= thr) && ({16'h0000, t_q} >= bterm);
  wire        done  = (op == `UBST_OP_INST) |
                      ((op == `UBST_OP_FIXED) & (t_q >= delay_i)) | // see [RQ2]
                      ((op == `UBST_OP_INV) & done_inv);
  wire        trip_n = start_n & (trip_o | done); // see [RQ1]
  wire [48:0] acc_s  = {1'b0, acc_q} + {17'h00000, inc};
  wire [15:0] t_inc  = (t_q == 16'hFFFF) ? t_q : t_q + 16'h0001; // see [RQ17]
  wire [47:0] acc_inc = acc_s[48] ? 48'hFFFFFFFFFFFF : acc_s[47:0];

  // outputs: trip only while started, instant trip shares the start edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      pick_o    <= 1'b0;
      start_o   <= 1'b0;
      trip_o    <= 1'b0;
      blocked_o <= 1'b0;
    end else begin
      pick_o    <= pick_n;
      start_o   <= start_n;
      trip_o    <= trip_n;
      blocked_o <= blk_n;
    end
  end

  // operate and release timers
  always @(posedge clk_i) begin
    if (rst_i) begin
      t_q    <= 16'h0000;
      acc_q  <= 48'h000000000000;
      rc_q   <= 16'h0000;
      ract_q <= 1'b0;
    end else if (start_n) begin
      ract_q <= 1'b0;
      if (tick_i) begin
        t_q   <= t_inc; // see [RQ17]
        acc_q <= acc_inc;
      end
    end else if (trip_o) begin
      t_q    <= 16'h0000; // reset after a trip, no release timing
      acc_q  <= 48'h000000000000;
      ract_q <= 1'b0;
    end else if (start_o) begin
      ract_q <= 1'b1; // early drop or blocking enters release, see [RQ6] [RQ14]
      rc_q   <= 16'h0000;
    end else if (ract_q && tick_i) begin
      if (rc_q + 16'h0001 >= release_i) begin
        ract_q <= 1'b0;
        t_q    <= 16'h0000;
        acc_q  <= 48'h000000000000;
      end else begin
        rc_q <= rc_q + 16'h0001;
        if (relop) begin
          t_q   <= t_inc; // see [RQ7]
          acc_q <= acc_inc;
        end
      end
    end
  end

  assign remain_o = (op == `UBST_OP_INST) ? 16'h0000 :
                    (op == `UBST_OP_FIXED) ? ((t_q >= delay_i) ? 16'h0000 : delay_i - t_q) : 16'hFFFF;
endmodule // ubst_stage
`default_nettype wire

// ===== tb/ubst_top_asserts.sv
// ubst_top_asserts.sv : port checks of stage 0 of the unbalance stage block
`timescale 1ns/1ps
`default_nettype none
module ubst_chk (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  block_i,
  input wire logic [3:0]  start_o,
  input wire logic [3:0]  trip_o,
  input wire logic [3:0]  blocked_o,
  input wire logic [23:0] event_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ----------
  // output levels and their event pulses
  // ----------
  sequence s_on(x); x && !$past(x); endsequence
  property p_trip_start; trip_o[0] |-> start_o[0]; endproperty
  a_trip_start: assert property (p_trip_start) else $error("trip without start");
  property p_trip_hold; $fell(trip_o[0]) |-> !start_o[0]; endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip fell while start stands");
  property p_excl; !(start_o[0] && blocked_o[0]); endproperty
  a_excl: assert property (p_excl) else $error("start and blocked together");
  property p_blk; blocked_o[0] |-> $past(block_i[0], 2); endproperty
  a_blk: assert property (p_blk) else $error("blocked without block input");
  property p_ev_son; event_o[0] |-> s_on(start_o[0]); endproperty
  a_ev_son: assert property (p_ev_son) else $error("start on event without edge");
  property p_ev_soff; event_o[1] |-> s_on(!start_o[0]); endproperty
  a_ev_soff: assert property (p_ev_soff) else $error("start off event without edge");
  property p_ev_ton; event_o[2] |-> s_on(trip_o[0]); endproperty
  a_ev_ton: assert property (p_ev_ton) else $error("trip on event without edge");
  property p_ev_bon; event_o[4] |-> s_on(blocked_o[0]); endproperty
  a_ev_bon: assert property (p_ev_bon) else $error("blocked on event without edge");
endmodule // ubst_chk
bind ubst_top ubst_chk i_ubst_chk (.ref_clk_i, .rst_i, .block_i, .start_o, .trip_o, .blocked_o, .event_o);
`default_nettype wire

// ===== tb/ubst_evbuf_model.sv
// ubst_evbuf_model.sv : common event buffer that stores stamped stage events
`timescale 1ns/1ps
`default_nettype none
module ubst_evbuf_model (
  input wire logic        clk_i,
  input wire logic [23:0] event_i,
  input wire logic [31:0] time_i,
  output var int          n_ev_o,
  output var logic [31:0] last_o
);
  initial n_ev_o = 0;
  // every set bit is one stored event sharing the stamp of its cycle
  always @(posedge clk_i) begin
    if (event_i != 24'h0) begin
      n_ev_o <= n_ev_o + $countones(event_i);
      last_o <= time_i;
    end
  end
endmodule // ubst_evbuf_model
`default_nettype wire

// ===== tb/tb_ubst_top.sv
// tb_ubst_top.sv : random and corner tests of the unbalance stage block
`timescale 1ns/1ps
`default_nettype none
module tb_ubst_top;
  localparam int TC = 20;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, lst;
  logic        wr = 1'b0, rd = 1'b0, irq;
  logic [15:0] neg = 16'h0000, pos = 16'h0000;
  logic [3:0]  blk = 4'h0, st, tr, bk;
  logic [2:0]  sg = 3'h0;
  logic [23:0] ev;
  logic [31:0] evt;
  int          n_fail = 0, compares = 0, cyc = 0, n_ev, n, d, v;
  ubst_top #(.TICK_CYCLES(TC)) i_ubst_top (.ref_clk_i, .rst_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .neg_seq_i(neg), .pos_seq_i(pos), .zero_seq_i(~pos), .neg_ang_i(pos ^ neg),
    .pos_ang_i(neg), .zero_ang_i(~neg), .block_i(blk), .setting_group_i(sg), .start_o(st), .trip_o(tr),
    .blocked_o(bk), .event_o(ev), .event_time_o(evt), .irq_o(irq));
  ubst_evbuf_model i_ubst_evbuf_model (.clk_i(ref_clk_i), .event_i(ev), .time_i(evt), .n_ev_o(n_ev), .last_o(lst));
  // ----------
  // clock, hang limit, helpers
  // ----------
  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  function automatic logic [23:0] ev4(input logic [5:0] k);
    return {4{k}};
  endfunction
  function automatic logic [31:0] rec_id(input logic [2:0] g, input logic [1:0] s, input logic [1:0] k);
    return {25'h0, g, s, k};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d0);
    @(posedge ref_clk_i);
    addr  <= a;
    wdata <= d0;
    wr    <= 1'b1;
    @(posedge ref_clk_i);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_i);
    rd   <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic cyc_n(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask
  // waits on trip (t) or start (!t) of stage 0, leaves the count in n
  task automatic wait_on(input logic t, input logic x);
    for (n = 0; n < 3000 && (t ? tr[0] : st[0]) !== x; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask
  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------
  // main sequence
  // ----------
  initial begin
    v = $urandom(77573);
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    sg    <= 3'($urandom);
    pos   <= 16'($urandom);
    rd_reg(8'h00, 32'h00FFFFFF);
    rd_reg(8'h80, 32'h41);
    rd_reg(8'h8C, 32'h3C);
    rd_reg(8'h10, 32'h0);
    rd_reg(8'h1C, 32'h0);
    for (int s = 0; s < 4; s++) wr_reg(8'h80 + 8'(s * 32), 32'h40);
    wr_reg(8'h0C, 32'hF);
    v = 257 + $urandom % 200;
    @(posedge ref_clk_i);
    neg <= 16'(v);
    wait_on(1'b0, 1'b1);
    chk({28'h0, tr}, 32'hF);
    chk({8'h0, ev}, {8'h0, ev4(6'h05)});
    chk(evt, 32'((cyc - 12) / TC));
    cyc_n(12);
    chk(32'(n_ev), 32'd8);
    rd_reg(8'h10, 32'd8);
    rd_reg(8'h24, rec_id(sg, 2'd3, 2'd1));
    rd_reg(8'h2C, 32'(v));
    chk({31'h0, irq}, 32'h1);
    wr_reg(8'h08, 32'hF);
    cyc_n(3);
    #1 chk({31'h0, irq}, 32'h0);
    // hysteresis edge just above and just below 97 percent
    @(posedge ref_clk_i);
    neg <= 16'h00F9;
    cyc_n(6);
    #1 chk({28'h0, st}, 32'hF);
    @(posedge ref_clk_i);
    neg <= 16'h00F8;
    wait_on(1'b0, 1'b0);
    chk({8'h0, ev}, {8'h0, ev4(6'h0A)});
    // random event mask, store overflow
    v = $urandom;
    wr_reg(8'h00, v);
    @(posedge ref_clk_i);
    neg <= 16'h0200;
    wait_on(1'b0, 1'b1);
    chk({8'h0, ev}, {8'h0, ev4(6'h05) & 24'(v)});
    cyc_n(12);
    rd_reg(8'h10, 32'd12);
    wr_reg(8'h00, 32'h00FFFFFF);
    // block while started
    @(posedge ref_clk_i);
    blk <= 4'h1;
    wait_on(1'b0, 1'b0);
    chk({28'h0, bk}, 32'h1);
    chk({28'h0, st}, 32'hE);
    @(posedge ref_clk_i);
    blk <= 4'h0;
    neg <= 16'h0000;
    // fixed delay of random length
    d = 3 + $urandom % 6;
    wr_reg(8'h80, 32'h41);
    wr_reg(8'h88, 32'(d));
    wr_reg(8'h8C, 32'h5);
    cyc_n(70 * TC);
    neg <= 16'h0200;
    wait_on(1'b0, 1'b1);
    wait_on(1'b1, 1'b1);
    chk({31'h0, n >= (d - 1) * TC && n <= d * TC + 3}, 32'h1);
    // short drop inside release keeps the elapsed time
    wr_reg(8'h88, 32'd10);
    @(posedge ref_clk_i);
    neg <= 16'h0000;
    cyc_n(8 * TC);
    neg <= 16'h0200;
    wait_on(1'b0, 1'b1);
    cyc_n(6 * TC);
    neg <= 16'h0000;
    cyc_n(2 * TC);
    neg <= 16'h0200;
    wait_on(1'b0, 1'b1);
    wait_on(1'b1, 1'b1);
    chk({31'h0, n <= 5 * TC + 4}, 32'h1);
    // quadratic curve
    wr_reg(8'h80, 32'h56);
    neg <= 16'h0000;
    wait_on(1'b0, 1'b0);
    @(posedge ref_clk_i);
    neg <= 16'h0101;
    wait_on(1'b0, 1'b1);
    wait_on(1'b1, 1'b1);
    chk({31'h0, n > TC && n <= 2 * TC + 3}, 32'h1);
    complete_run;
  end
endmodule // tb_ubst_top
`default_nettype wire
